// *** bmc_ctrl.v ***
//
// Contract
// - In pure external burst with open-pin detection on, 32 packets with the auxiliary sense pin low and the loop error above the burst threshold latch a shutdown fault.
// - The loop error burst comparator stays on in sleep as the wake source, with one of three selectable wake thresholds.
// - The external burst comparator steers burst entry and exit only when the external burst enable bit is set.
// - A slow always-on tick runs continuously, sleep included, and times the sleep logic.
// - In deep sleep the line, wake comparator and supply monitors stay enabled and memory is retained.
// - The decision source is selectable: loop error only, external comparator only, or hybrid.
// - In loop error mode the block enters sleep when the loop error falls below the entry threshold.
// - Switching for each burst starts only after the burst comparator has triggered.
// - The gap between bursts is measured and normal switching resumes when it is shorter than a set threshold.
// - Burst mode also ends at once if the loop error is still above the burst threshold after a packet.
// - In pure external mode only the external comparator decides burst entry and exit.
// - In hybrid mode a high external comparator keeps burst mode off, a low one hands the decision to the loop error rules.
// - In both external modes the start of switching in a burst still follows the burst comparator.
// - During burst mode the PFC and resonant stage switching start and stop together.
// - A resonant burst may run without the PFC stage when the system asks for it.
`timescale 1ns/1ns
`include "bmc_consts.vh"
module bmc_ctrl #(
  parameter SLOW_DIV = `BMC_SLOW_DIV,
  parameter GAP_W = 16
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Register port
  input wire [`BMC_ADDR_W-1:0] i_addr,
  input wire [`BMC_DATA_W-1:0] i_wr_data,
  input wire i_wr,
  input wire i_rd,
  output reg [`BMC_DATA_W-1:0] o_rd_data,
  // Analog comparator levels, asynchronous
  input wire i_loop_err_high,
  input wire i_loop_err_low,
  input wire i_ext_burst_cmp,
  input wire i_aux_sense_low,
  // Switching sequencers, same clock
  input wire i_packet_done,
  input wire i_pfc_skip,
  // Switching gates
  output reg o_res_run,
  output reg o_pfc_run,
  // Mode and fault status
  output reg o_burst_mode,
  output reg o_sleep,
  output reg o_aux_pin_open_fault,
  // Comparator threshold selects
  output reg [1:0] o_wake_sel,
  output reg [1:0] o_entry_sel,
  // Monitors kept alive in sleep
  output reg o_line_mon_en,
  output reg o_wake_cmp_en,
  output reg o_vcc_mon_en,
  output reg o_ram_retain,
  output reg o_slow_tick
);

  localparam [1:0] ST_NORMAL = 2'h0;
  localparam [1:0] ST_SLEEP = 2'h1;
  localparam [1:0] ST_BURST = 2'h2;
  localparam [1:0] ST_FAULT = 2'h3;
  // Divider end count, cut on purpose to the width of the counter
  localparam integer DIV_LAST_I = SLOW_DIV - 1;
  localparam [13:0] DIV_LAST = DIV_LAST_I[13:0];
  localparam [GAP_W-1:0] GAP_MAX = {GAP_W{1'b1}};

  // Synchronised comparator levels
  wire err_high;
  wire err_low;
  wire ext_high;
  wire aux_low;

  // Configuration
  reg [`BMC_DATA_W-1:0] ctrl;
  reg [GAP_W-1:0] gap_thr;

  // State
  reg [1:0] state;
  reg [1:0] next_state;
  reg [13:0] div_cnt;
  reg [GAP_W-1:0] gap_cnt;
  reg [GAP_W-1:0] last_gap;
  reg first_burst;
  reg aux_seen_high;
  reg [5:0] open_cnt;

  // Decoded configuration
  wire [1:0] src = ctrl[`BMC_CTRL_SRC_MSB:`BMC_CTRL_SRC_LSB];
  wire ext_en = ctrl[`BMC_CTRL_EXT_EN];
  wire disc_en = ctrl[`BMC_CTRL_DISC_EN];
  // External codes count only with the enable bit set, otherwise the
  // block falls back to loop error rules, so a stray source code is safe
  wire pure_mode = ext_en && (src == `BMC_SRC_PURE);
  wire hybrid_mode = ext_en && (src == `BMC_SRC_HYBRID);
  // Loop error rules apply in loop and hybrid modes
  wire loop_rules = !pure_mode;

  // One synchroniser per comparator level
  // Two flops each; decisions lag the pins by two cycles
  bmc_sync u_sync_err_high (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_loop_err_high),
    .o_sync(err_high)
  );
  bmc_sync u_sync_err_low (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_loop_err_low),
    .o_sync(err_low)
  );
  bmc_sync u_sync_ext (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_ext_burst_cmp),
    .o_sync(ext_high)
  );
  bmc_sync u_sync_aux (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async(i_aux_sense_low),
    .o_sync(aux_low)
  );

  // Whether the selected source asks for burst entry or forces exit
  reg want_enter;
  reg force_exit;
  always @* begin
    want_enter = 1'b0;
    force_exit = 1'b0;
    if (pure_mode) begin
      want_enter = !ext_high;
      force_exit = ext_high;
    end else if (hybrid_mode) begin
      want_enter = !ext_high && err_low;
      force_exit = ext_high;
    end else begin
      want_enter = err_low;
    end
  end

  // Gap below threshold means the load is heavy enough to leave bursts
  wire gap_short = loop_rules && !first_burst && (gap_cnt < gap_thr);
  // Packet ended with the auxiliary pin low all along and loop error high
  wire open_hit = pure_mode && !aux_seen_high && err_high;

  // Status word: open count on top, synced levels, then mode and state
  // The levels are the synchronised copies, so software sees what the
  // decisions see, two cycles behind the pins
  wire [`BMC_DATA_W-1:0] status_word = {open_cnt, 2'h0, ext_high, err_low,
    err_high, o_aux_pin_open_fault, o_sleep, o_burst_mode, state};

  // Next state
  always @* begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        if (want_enter) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (force_exit) begin
          next_state = ST_NORMAL;
        end else if (err_high && gap_short) begin
          next_state = ST_NORMAL;
        end else if (err_high) begin
          next_state = ST_BURST;
        end
      end
      ST_BURST: begin
        // Decisions only at a packet end, so a packet is never cut short;
        // the fault check goes first so a forced exit cannot hide it
        if (i_packet_done) begin
          if (disc_en && open_hit && open_cnt == `BMC_OPEN_PACKETS - 6'h01) begin
            next_state = ST_FAULT;
          end else if (force_exit) begin
            next_state = ST_NORMAL;
          end else if (loop_rules && err_high) begin
            next_state = ST_NORMAL;
          end else begin
            next_state = ST_SLEEP;
          end
        end
      end
      ST_FAULT: begin
        // Only reset leaves the fault, so switching stays stopped
        next_state = ST_FAULT; // Latched until reset
      end
      default: begin
        next_state = ST_NORMAL;
      end
    endcase
  end

  // Slow tick divider, free running in every state
  // It never stops, so sleep timing holds even with switching halted
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      div_cnt <= 14'h0000;
      o_slow_tick <= 1'b0;
    end else if (div_cnt == DIV_LAST) begin
      div_cnt <= 14'h0000;
      o_slow_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 14'h0001;
      o_slow_tick <= 1'b0;
    end
  end

  // State register and gap measurement
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      state <= ST_NORMAL;
      gap_cnt <= {GAP_W{1'b0}};
      last_gap <= {GAP_W{1'b0}};
      first_burst <= 1'b1;
    end else begin
      state <= next_state;
      if (state == ST_SLEEP && next_state == ST_BURST) begin
        last_gap <= gap_cnt;
        first_burst <= 1'b0;
      end
      // Gap counts slow ticks from end of one packet to the next wake;
      // it saturates so a very long sleep never wraps into a short gap
      if (state != ST_SLEEP) begin
        gap_cnt <= {GAP_W{1'b0}};
      end else if (o_slow_tick && gap_cnt != GAP_MAX) begin
        gap_cnt <= gap_cnt + {{(GAP_W-1){1'b0}}, 1'b1};
      end
      // No gap exists before the first burst after normal running, so
      // that burst is never judged against the interval threshold
      if (next_state == ST_NORMAL) begin
        first_burst <= 1'b1;
      end
    end
  end

  // Open auxiliary pin watch, per packet
  // A packet counts only if the pin never rose within it; one good packet
  // clears the run, so a noisy pin cannot build up a false fault
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      aux_seen_high <= 1'b0;
      open_cnt <= 6'h00;
    end else begin
      if (state != ST_BURST || i_packet_done) begin
        aux_seen_high <= 1'b0;
      end else if (!aux_low) begin
        aux_seen_high <= 1'b1;
      end
      if (!pure_mode || state == ST_NORMAL) begin
        open_cnt <= 6'h00;
      end else if (state == ST_BURST && i_packet_done) begin
        if (open_hit && open_cnt != `BMC_OPEN_PACKETS) begin
          open_cnt <= open_cnt + 6'h01;
        end else if (!open_hit) begin
          open_cnt <= 6'h00;
        end
      end
    end
  end

  // Registered outputs; both stages gated from one state
  // Outputs follow the next state so they change on the same edge as it
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_res_run <= 1'b1;
      o_pfc_run <= 1'b1;
      o_burst_mode <= 1'b0;
      o_sleep <= 1'b0;
      o_aux_pin_open_fault <= 1'b0;
      o_wake_sel <= `BMC_WAKE_1V00;
      o_entry_sel <= 2'h0;
      o_line_mon_en <= 1'b1;
      o_wake_cmp_en <= 1'b1;
      o_vcc_mon_en <= 1'b1;
      o_ram_retain <= 1'b1;
    end else begin
      o_res_run <= (next_state == ST_NORMAL) ||
        (next_state == ST_BURST);
      o_pfc_run <= (next_state == ST_NORMAL) ||
        (next_state == ST_BURST && !i_pfc_skip);
      o_burst_mode <= (next_state == ST_SLEEP) || (next_state == ST_BURST);
      o_sleep <= (next_state == ST_SLEEP);
      o_aux_pin_open_fault <= (next_state == ST_FAULT);
      o_wake_sel <= ctrl[`BMC_CTRL_WAKE_MSB:`BMC_CTRL_WAKE_LSB];
      o_entry_sel <= ctrl[`BMC_CTRL_ENTRY_MSB:`BMC_CTRL_ENTRY_LSB];
      // Monitors never drop, sleep gates only the switching
      o_line_mon_en <= 1'b1;
      o_wake_cmp_en <= 1'b1;
      o_vcc_mon_en <= 1'b1;
      o_ram_retain <= 1'b1;
    end
  end

  // Register writes
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl <= `BMC_CTRL_RESET;
      gap_thr <= `BMC_INTERVAL_RESET;
    end else if (i_wr) begin
      case (i_addr)
        `BMC_REG_CTRL: begin
          ctrl <= {8'h00, i_wr_data[7:0]};
        end
        `BMC_REG_INTERVAL: begin
          gap_thr <= i_wr_data[GAP_W-1:0];
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // Register reads, data stands one cycle after the strobe only
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rd_data <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        `BMC_REG_CTRL: begin
          o_rd_data <= ctrl;
        end
        `BMC_REG_INTERVAL: begin
          o_rd_data <= gap_thr;
        end
        `BMC_REG_STATUS: begin
          o_rd_data <= status_word;
        end
        `BMC_REG_LAST_GAP: begin
          o_rd_data <= last_gap;
        end
        default: begin
          o_rd_data <= 16'h0000;
        end
      endcase
    end else begin
      o_rd_data <= 16'h0000;
    end
  end

endmodule

// *** bmc_consts.vh ***
`ifndef BMC_CONSTS_VH
`define BMC_CONSTS_VH

// Clock and slow system tick
`define BMC_CLK_HZ 250000000
`define BMC_SLOW_HZ 30000
`define BMC_SLOW_DIV (`BMC_CLK_HZ / `BMC_SLOW_HZ)

// Register index map
`define BMC_ADDR_W 4
`define BMC_DATA_W 16
`define BMC_REG_CTRL 4'h0
`define BMC_REG_INTERVAL 4'h1
`define BMC_REG_STATUS 4'h2
`define BMC_REG_LAST_GAP 4'h3

// Control register fields
`define BMC_CTRL_SRC_LSB 0
`define BMC_CTRL_SRC_MSB 1
`define BMC_CTRL_EXT_EN 2
`define BMC_CTRL_DISC_EN 3
`define BMC_CTRL_WAKE_LSB 4
`define BMC_CTRL_WAKE_MSB 5
`define BMC_CTRL_ENTRY_LSB 6
`define BMC_CTRL_ENTRY_MSB 7
`define BMC_CTRL_RESET 16'h0010

// Decision source encodings
`define BMC_SRC_LOOP 2'h0
`define BMC_SRC_PURE 2'h1
`define BMC_SRC_HYBRID 2'h2

// Wake threshold select encodings
`define BMC_WAKE_0V75 2'h0
`define BMC_WAKE_1V00 2'h1
`define BMC_WAKE_1V25 2'h2

// Exit interval threshold, in slow ticks
`define BMC_INTERVAL_RESET 16'h0020

// Packets of a stuck auxiliary sense pin before the fault latches
`define BMC_OPEN_PACKETS 6'h20

`endif

// *** bmc_sync.v ***
`timescale 1ns/1ns
// Two-stage synchroniser for one asynchronous comparator level
module bmc_sync #(
  parameter RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Level in and out
  input wire i_async,
  output reg o_sync
);

  reg meta;

  // First stage feeds only the second stage
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// *** bmc_ctrl_checker.sv ***
`timescale 1ns/1ns
`include "bmc_consts.vh"
module bmc_ctrl_checker #(
  parameter SLOW_DIV = `BMC_SLOW_DIV
) (
  // Clock, reset and bus
  input wire i_clk,
  input wire i_rst_b,
  input wire i_rd,
  input wire [`BMC_DATA_W-1:0] o_rd_data,
  // Comparator levels
  input wire i_loop_err_high,
  input wire i_loop_err_low,
  input wire i_ext_burst_cmp,
  // Gates and status
  input wire o_res_run,
  input wire o_pfc_run,
  input wire o_burst_mode,
  input wire o_sleep,
  input wire o_aux_pin_open_fault,
  input wire o_slow_tick
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  reg [15:0] tick_gap;
  reg tick_seen;
  // Cycles since the last slow tick; the first tick only arms the count
  always @(posedge i_clk) begin
    if (!i_rst_b) begin
      tick_gap <= 16'h0000;
      tick_seen <= 1'b0;
    end else if (o_slow_tick) begin
      tick_gap <= 16'h0000;
      tick_seen <= 1'b1;
    end else begin
      tick_gap <= tick_gap + 16'h0001;
    end
  end
  // Two sync stages and the output flop, so causes lie three samples back
  slow_tick_period_a: assert property (
    o_slow_tick && tick_seen |-> tick_gap == SLOW_DIV - 1)
    else $error("slow tick period wrong");
  slow_tick_alive_a: assert property (
    tick_seen |-> tick_gap < SLOW_DIV) else $error("slow tick missing");
  sleep_gates_off_a: assert property (
    o_sleep |-> o_burst_mode && !o_res_run && !o_pfc_run)
    else $error("switching while asleep");
  pfc_with_res_a: assert property (
    o_pfc_run |-> o_res_run) else $error("pfc runs alone");
  entry_cause_a: assert property (
    $rose(o_burst_mode) |->
      $past(i_loop_err_low, 3) || !$past(i_ext_burst_cmp, 3))
    else $error("burst entry without cause");
  wake_cause_a: assert property (
    $rose(o_res_run) && o_burst_mode |-> $past(i_loop_err_high, 3))
    else $error("burst start without wake");
  fault_held_a: assert property (
    o_aux_pin_open_fault |=> o_aux_pin_open_fault)
    else $error("fault not latched");
  fault_stops_a: assert property (
    o_aux_pin_open_fault |-> !o_res_run && !o_pfc_run && !o_sleep)
    else $error("switching during fault");
  exit_normal_a: assert property (
    $fell(o_burst_mode) && !o_aux_pin_open_fault |-> o_res_run && o_pfc_run)
    else $error("burst exit without switching");
  rd_idle_a: assert property (
    !$past(i_rd) |-> o_rd_data == 16'h0000) else $error("read data not idle");
endmodule

bind bmc_ctrl bmc_ctrl_checker #(.SLOW_DIV(SLOW_DIV)) u_bmc_ctrl_checker (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_rd(i_rd), .o_rd_data(o_rd_data),
  .i_loop_err_high(i_loop_err_high), .i_loop_err_low(i_loop_err_low),
  .i_ext_burst_cmp(i_ext_burst_cmp), .o_res_run(o_res_run),
  .o_pfc_run(o_pfc_run), .o_burst_mode(o_burst_mode), .o_sleep(o_sleep),
  .o_aux_pin_open_fault(o_aux_pin_open_fault), .o_slow_tick(o_slow_tick)
);

// *** bmc_seq_model.sv ***
`timescale 1ns/1ns
module bmc_seq_model (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_b,
  // Gates and packet length
  input wire i_res_run,
  input wire i_burst_mode,
  input wire [3:0] i_len,
  // End of packet
  output reg o_packet_done
);
  reg [3:0] cnt;
  // A packet runs only while the resonant gate is open in burst mode
  always @(posedge i_clk) begin
    if (!i_rst_b || !i_res_run || !i_burst_mode || o_packet_done) begin
      cnt <= 4'h0;
      o_packet_done <= 1'b0;
    end else if (cnt == i_len) begin
      o_packet_done <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// *** burst_mode_controller_test.sv ***
`timescale 1ns/1ns
module burst_mode_controller_test;
  reg i_clk = 1'b0;
  reg i_rst_b = 1'b0;
  reg [3:0] i_addr = 4'h0;
  reg [15:0] i_wr_data = 16'h0000;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg hi = 1'b0;
  reg lo = 1'b0;
  reg ext = 1'b1;
  reg aux = 1'b0;
  reg skip = 1'b0;
  reg [3:0] len = 4'h4;
  wire pkt, res, pfc, bm, slp, flt, lm, wc, vm, rr;
  wire [15:0] rdat;
  wire [1:0] ws, es;
  int n_fail = 0;
  int checks_done = 0;
  int npk = 0;
  int k;
  // Control word, lo, ext, expected sleep
  logic [18:0] rows [5] = '{19'h00088, 19'h000A9, 19'h000B6, 19'h000B0,
    19'h000B5};
  // 250 MHz clock
  always #2 i_clk = ~i_clk;
  // Packet count for the open pin run
  always @(posedge i_clk) if (pkt) npk <= npk + 1;
  bmc_ctrl #(.SLOW_DIV(8)) u_bmc_ctrl (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(rdat),
    .i_loop_err_high(hi), .i_loop_err_low(lo), .i_ext_burst_cmp(ext),
    .i_aux_sense_low(aux), .i_packet_done(pkt), .i_pfc_skip(skip),
    .o_res_run(res), .o_pfc_run(pfc), .o_burst_mode(bm), .o_sleep(slp),
    .o_aux_pin_open_fault(flt), .o_wake_sel(ws), .o_entry_sel(es),
    .o_line_mon_en(lm), .o_wake_cmp_en(wc), .o_vcc_mon_en(vm),
    .o_ram_retain(rr), .o_slow_tick());
  bmc_seq_model u_bmc_seq_model (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_res_run(res), .i_burst_mode(bm), .i_len(len), .o_packet_done(pkt));
  task chk(input [15:0] seen, input [15:0] exp, input [63:0] nm);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [3:0] a, input [15:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(rdat, e, "rd_data");
  endtask
  function logic cur(input int s);
    case (s)
      0: cur = slp;
      1: cur = bm;
      2: cur = res;
      default: cur = flt;
    endcase
  endfunction
  // Bounded wait for one status output
  task wt(input int s, input logic v);
    int i;
    i = 0;
    while (i < 1000 && cur(s) !== v) begin
      @(posedge i_clk);
      #1 i++;
    end
    chk({15'h0000, cur(s)}, {15'h0000, v}, "wait_out");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    #40000;
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rd(4'h0, 16'h0010);
    rd(4'h1, 16'h0020);
    wr(4'h5, 16'hFFFF);
    rd(4'h5, 16'h0000);
    rd(4'h0, 16'h0010);
    chk({12'h000, lm, wc, vm, rr}, 16'h000F, "monitors");
    for (k = 0; k < 3; k++) begin
      wr(4'h0, 16'hFF00 | 16'(k) * 16'h0050);
      rd(4'h0, 16'(k) * 16'h0050);
      chk({12'h000, ws, es}, 16'(k) * 16'h0005, "selects");
    end
    $display("test registers done");
    wr(4'h0, 16'h0010);
    for (k = 0; k < 2; k++) begin
      @(posedge i_clk);
      skip <= k[0];
      len <= k ? 4'hC : 4'h3;
      lo <= 1'b1;
      wt(0, 1'b1);
      chk({14'h0000, res, pfc}, 16'h0000, "gates");
      @(posedge i_clk);
      hi <= 1'b1;
      wt(2, 1'b1);
      chk({15'h0000, pfc}, {15'h0000, ~k[0]}, "pfc_run");
      @(posedge i_clk);
      lo <= 1'b0;
      wt(1, 1'b0);
      chk({14'h0000, res, pfc}, 16'h0003, "normal");
      @(posedge i_clk);
      hi <= 1'b0;
    end
    $display("test loop_burst done");
    for (k = 0; k < 2; k++) begin
      wr(4'h1, k ? 16'h0001 : 16'h0020);
      @(posedge i_clk);
      lo <= 1'b1;
      wt(0, 1'b1);
      @(posedge i_clk);
      hi <= 1'b1;
      wt(2, 1'b1);
      @(posedge i_clk);
      hi <= 1'b0;
      lo <= 1'b0;
      wt(0, 1'b1);
      repeat (k ? 40 : 2) @(posedge i_clk);
      hi <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1 chk({15'h0000, bm}, {15'h0000, k[0]}, "gap");
      wt(1, 1'b0);
      @(posedge i_clk);
      hi <= 1'b0;
    end
    $display("test gap done");
    for (k = 0; k < 5; k++) begin
      wr(4'h0, rows[k][18:3]);
      @(posedge i_clk);
      lo <= rows[k][2];
      ext <= rows[k][1];
      repeat (6) @(posedge i_clk);
      #1 chk({15'h0000, slp}, {15'h0000, rows[k][0]}, "ext_mode");
      @(posedge i_clk);
      ext <= 1'b1;
      lo <= 1'b0;
      wt(1, 1'b0);
    end
    $display("test ext_modes done");
    wr(4'h0, 16'h001D);
    @(posedge i_clk);
    k = npk;
    len <= 4'h2;
    aux <= 1'b1;
    hi <= 1'b1;
    ext <= 1'b0;
    wt(3, 1'b1);
    chk(16'(npk - k), 16'h0020, "packets");
    chk({14'h0000, res, pfc}, 16'h0000, "stopped");
    rd(4'h2, 16'h8033);
    rd(4'h3, 16'h0000);
    $display("test open_pin done");
    complete_run;
  end
endmodule
